// ### src/srr_pkg.sv
/*
 * Shared constants and types of the sample recorder readout block.
 * Assumes one clock domain; the host command port and the sample
 * source run on that clock.
 */
package srr_pkg;

    // ------------------------------------------------------------
    // buffer geometry
    // ------------------------------------------------------------
    localparam int          SRR_AW    = 10;
    localparam int          SRR_DEPTH = 1 << SRR_AW;
    localparam int          SRR_DW    = 16;
    localparam logic [10:0] SRR_FULL  = 11'(SRR_DEPTH);
    localparam logic [9:0]  SRR_LAST  = 10'(SRR_DEPTH - 1);

    // ------------------------------------------------------------
    // reset values and encodings of the settings
    // ------------------------------------------------------------
    localparam logic [15:0] SRR_SIZE_RST   = 16'h03E8;
    localparam logic        SRR_STOP_ONCE  = 1'h0;
    localparam logic        SRR_STOP_CONT  = 1'h1;
    localparam logic        SRR_STOP_RST   = SRR_STOP_ONCE;
    localparam logic [1:0]  SRR_TRIG_NOW   = 2'h0;
    localparam logic [1:0]  SRR_TRIG_RISE  = 2'h1;
    localparam logic [1:0]  SRR_TRIG_FALL  = 2'h2;
    localparam logic [1:0]  SRR_TRIG_RST   = SRR_TRIG_NOW;
    localparam logic [15:0] SRR_GAP_RST    = 16'h0001;
    localparam logic [15:0] SRR_CHAN_RST   = 16'h0000;
    localparam logic [1:0]  SRR_HDR_WORDS  = 2'h3;

    typedef enum logic [3:0] {
        SRR_CMD_NOP      = 4'h0,
        SRR_CMD_ARM      = 4'h1,
        SRR_CMD_OFF      = 4'h2,
        SRR_CMD_HEADER   = 4'h3,
        SRR_CMD_SECTION  = 4'h4,
        SRR_CMD_FULL     = 4'h5,
        SRR_CMD_SET_STOP = 4'h6,
        SRR_CMD_SET_SIZE = 4'h7,
        SRR_CMD_SET_TRIG = 4'h8,
        SRR_CMD_SET_GAP  = 4'h9,
        SRR_CMD_SET_CHAN = 4'hA
    } srr_cmd_e;

    typedef enum logic [2:0] {
        SRR_ERR_NONE     = 3'h0,
        SRR_ERR_LOCKED   = 3'h1,
        SRR_ERR_BUSY     = 3'h2,
        SRR_ERR_OVERFLOW = 3'h3,
        SRR_ERR_EMPTY    = 3'h4,
        SRR_ERR_BADCMD   = 3'h5
    } srr_err_e;

    typedef enum logic {
        SRR_KIND_HDR  = 1'h0,
        SRR_KIND_DATA = 1'h1
    } srr_kind_e;

    typedef struct packed {
        srr_cmd_e    code;
        logic        idxValid;
        logic [15:0] arg;
    } srr_cmd_s;

    typedef struct packed {
        srr_kind_e   kind;
        logic        last;
        logic [15:0] data;
    } srr_word_s;

endpackage

// ### src/srr_recorder.sv
/*
 * Recorder control, recording buffer and readout streamer.
 * Assumes host commands and samples arrive on mclk; the trigger pin
 * is asynchronous and is synchronised here.
 */
`timescale 1ns/1ns

// Functional notes
// - header request sends header words, no samples
// - section size register, 0..65535, default 1000
// - stop type zero fills buffer once
// - stop type one records circularly, overwriting oldest
// - off command stops sample writing
// - arm waits for configured trigger type
// - arm clears recording complete flag
// - arm discards previous recording data
// - settings writes refused while recorder armed
// - section read during single recording errors
// - continuous overrun reports overflow, no data
// - continuous sections continue, wrapping at end
// - arm resets section read index
module srr_recorder
    import srr_pkg::*;
(
    // clock and reset
    input  wire logic      mclk,
    input  wire logic      nrst,
    // host commands
    input  wire logic      cmdValid,
    input  wire srr_cmd_s  cmd,
    output logic           cmdReady,
    // samples and trigger pin
    input  wire logic      sampleValid,
    input  wire logic [15:0] sampleData,
    input  wire logic      trigPin,
    // readout stream
    output logic           outValid,
    output srr_word_s      outWord,
    input  wire logic      outReady,
    // status
    output logic           recordingComplete,
    output logic           settingsLocked,
    output logic           errValid,
    output srr_err_e       errCode,
    output logic [15:0]    sectionSize,
    output logic           stopType
);

    default clocking @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    typedef enum logic [2:0] {
        REC_IDLE  = 3'b001,
        REC_ARMED = 3'b010,
        REC_RUN   = 3'b100
    } srr_rec_e;

    typedef enum logic [2:0] {
        RD_IDLE = 3'b001,
        RD_HDR  = 3'b010,
        RD_DATA = 3'b100
    } srr_rd_e;

    // ------------------------------------------------------------
    // trigger pin synchroniser
    // ------------------------------------------------------------
    logic [2:0] trigSync_q;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            trigSync_q <= 3'h0;
        end else begin
            trigSync_q <= {trigSync_q[1:0], trigPin};
        end
    end
    logic trigRise;
    logic trigFall;
    assign trigRise = trigSync_q[1] & ~trigSync_q[2];
    assign trigFall = ~trigSync_q[1] & trigSync_q[2];

    function automatic logic isSetting(input srr_cmd_e c);
        isSetting = (c == SRR_CMD_SET_STOP) || (c == SRR_CMD_SET_SIZE) ||
                    (c == SRR_CMD_SET_TRIG) || (c == SRR_CMD_SET_GAP) ||
                    (c == SRR_CMD_SET_CHAN);
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    srr_rec_e    rec_q, rec_d;
    srr_rd_e     rd_q, rd_d;
    logic        stop_q, stop_d;
    logic [15:0] size_q, size_d;
    logic [1:0]  trig_q, trig_d;
    logic [15:0] gap_q, gap_d, chan_q, chan_d, gapCnt_q, gapCnt_d;
    logic        done_q, done_d, withData_q, withData_d;
    logic [10:0] filled_q, filled_d, remain_q, remain_d;
    logic [9:0]  wrPtr_q, wrPtr_d, rdIdx_q, rdIdx_d, cur_q, cur_d;
    logic [16:0] wrTot_q, wrTot_d, rdTot_q, rdTot_d;
    logic [1:0]  hdrCnt_q, hdrCnt_d, bufCnt_q, bufCnt_d;
    logic        errValid_q, errValid_d, ready_q, ready_d;
    logic        outValid_q, lock_q, lock_d;
    srr_err_e    err_q, err_d;
    srr_word_s   buf_q [2];
    srr_word_s   buf_d [2];

    logic [SRR_DW-1:0] mem [SRR_DEPTH];
    logic        wrEn;
    logic        push, pop;
    srr_word_s   pushWord;
    logic        accept;
    logic [16:0] unread;
    logic [10:0] sizeClamp, limit, count;
    logic        trigHit;

    assign accept    = cmdValid & ready_q;
    assign unread    = wrTot_q - rdTot_q;
    assign sizeClamp = (size_q > 16'(SRR_FULL)) ? SRR_FULL : size_q[10:0];

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        rec_d = rec_q;      rd_d = rd_q;         stop_d = stop_q;
        size_d = size_q;    trig_d = trig_q;     gap_d = gap_q;
        chan_d = chan_q;    gapCnt_d = gapCnt_q; done_d = done_q;
        withData_d = withData_q; filled_d = filled_q;
        remain_d = remain_q; wrPtr_d = wrPtr_q;  rdIdx_d = rdIdx_q;
        cur_d = cur_q;      wrTot_d = wrTot_q;   rdTot_d = rdTot_q;
        hdrCnt_d = hdrCnt_q; errValid_d = 1'b0;  err_d = err_q;
        wrEn = 1'b0;        push = 1'b0;         pushWord = '0;
        limit = (stop_q == SRR_STOP_CONT) ? unread[10:0] : filled_q;
        count = (sizeClamp < limit) ? sizeClamp : limit;
        trigHit = 1'b0;
        // recording side
        case (rec_q)
            REC_ARMED: begin
                // trigger type chooses the start event
                case (trig_q)
                    SRR_TRIG_RISE: trigHit = trigRise;
                    SRR_TRIG_FALL: trigHit = trigFall;
                    default:       trigHit = 1'b1;
                endcase
                if (trigHit) begin
                    rec_d = REC_RUN;
                end
            end
            REC_RUN: begin
                if (sampleValid) begin
                    gapCnt_d = (gapCnt_q == 16'h0) ? gap_q - 16'h1
                                                   : gapCnt_q - 16'h1;
                    if (gapCnt_q == 16'h0) begin
                        wrEn = 1'b1;
                        wrPtr_d = wrPtr_q + 10'h1;
                        wrTot_d = wrTot_q + 17'h1;
                        if (filled_q != SRR_FULL) begin
                            filled_d = filled_q + 11'h1;
                        end
                        // single fill stops at buffer end
                        if (stop_q == SRR_STOP_ONCE &&
                            wrPtr_q == SRR_LAST) begin
                            done_d = 1'b1;
                            rec_d  = REC_IDLE;
                        end
                    end
                end
            end
            default: ;
        endcase
        // readout side, the buffer stalls it
        if (bufCnt_q != 2'h2) begin
            case (rd_q)
                RD_HDR: begin
                    push = 1'b1;
                    pushWord.kind = SRR_KIND_HDR;
                    case (hdrCnt_q)
                        2'h0:    pushWord.data = {5'h0, filled_q};
                        2'h1:    pushWord.data = gap_q;
                        default: pushWord.data = chan_q;
                    endcase
                    pushWord.last = (hdrCnt_q == SRR_HDR_WORDS - 2'h1) &&
                                    (!withData_q || remain_q == 11'h0);
                    hdrCnt_d = hdrCnt_q + 2'h1;
                    if (hdrCnt_q == SRR_HDR_WORDS - 2'h1) begin
                        rd_d = (withData_q && remain_q != 11'h0) ? RD_DATA
                                                                 : RD_IDLE;
                    end
                end
                RD_DATA: begin
                    push = 1'b1;
                    pushWord.kind = SRR_KIND_DATA;
                    pushWord.data = mem[cur_q];
                    pushWord.last = (remain_q == 11'h1);
                    cur_d    = cur_q + 10'h1;
                    remain_d = remain_q - 11'h1;
                    if (remain_q == 11'h1) begin
                        rd_d = RD_IDLE;
                    end
                end
                default: ;
            endcase
        end
        // host commands
        if (accept) begin
            if (isSetting(cmd.code) && rec_q != REC_IDLE) begin
                // settings locked until finished or off
                errValid_d = 1'b1;
                err_d      = SRR_ERR_LOCKED;
            end else begin
                case (cmd.code)
                    SRR_CMD_ARM: begin
                        done_d = 1'b0;
                        filled_d = 11'h0;
                        wrPtr_d  = 10'h0;
                        wrTot_d  = 17'h0;
                        rdTot_d  = 17'h0;
                        gapCnt_d = 16'h0;
                        rdIdx_d  = 10'h0;
                        rec_d    = REC_ARMED;
                    end
                    SRR_CMD_OFF:      rec_d  = REC_IDLE;
                    SRR_CMD_SET_STOP: stop_d = cmd.arg[0];
                    SRR_CMD_SET_SIZE: size_d = cmd.arg;
                    SRR_CMD_SET_TRIG: trig_d = cmd.arg[1:0];
                    SRR_CMD_SET_GAP: begin
                        gap_d = (cmd.arg == 16'h0) ? SRR_GAP_RST : cmd.arg;
                    end
                    SRR_CMD_SET_CHAN: chan_d = cmd.arg;
                    SRR_CMD_HEADER, SRR_CMD_FULL: begin
                        if (cmd.code == SRR_CMD_FULL && rec_q != REC_IDLE &&
                            stop_q == SRR_STOP_ONCE) begin
                            errValid_d = 1'b1;
                            err_d      = SRR_ERR_BUSY;
                        end else begin
                            withData_d = (cmd.code == SRR_CMD_FULL);
                            remain_d   = filled_q;
                            cur_d      = (filled_q == SRR_FULL) ? wrPtr_q
                                                                : 10'h0;
                            hdrCnt_d   = 2'h0;
                            rd_d       = RD_HDR;
                        end
                    end
                    SRR_CMD_SECTION: begin
                        errValid_d = 1'b1;
                        if (rec_q != REC_IDLE && stop_q == SRR_STOP_ONCE) begin
                            err_d = SRR_ERR_BUSY;
                        end else if (stop_q == SRR_STOP_CONT &&
                                     unread > 17'(SRR_FULL)) begin
                            err_d = SRR_ERR_OVERFLOW;
                        end else if (filled_q == 11'h0) begin
                            err_d = SRR_ERR_EMPTY;
                        end else begin
                            errValid_d = 1'b0;
                            cur_d = (stop_q == SRR_STOP_ONCE &&
                                     cmd.idxValid &&
                                     {5'h0, filled_q} > cmd.arg)
                                    ? cmd.arg[9:0] : rdIdx_q;
                            rdIdx_d  = cur_d + count[9:0];
                            rdTot_d  = rdTot_q + {6'h0, count};
                            remain_d = count;
                            if (count != 11'h0) begin
                                rd_d = RD_DATA;
                            end
                        end
                    end
                    default: begin
                        errValid_d = 1'b1;
                        err_d      = SRR_ERR_BADCMD;
                    end
                endcase
            end
        end
        ready_d = (rd_d == RD_IDLE);
        lock_d  = (rec_d != REC_IDLE);
    end

    // ------------------------------------------------------------
    // two-entry output buffer, head always in slot 0
    // ------------------------------------------------------------
    assign pop = outValid_q & outReady;
    always_comb begin
        buf_d[0] = buf_q[0];
        buf_d[1] = buf_q[1];
        bufCnt_d = bufCnt_q;
        if (pop) begin
            buf_d[0] = buf_q[1];
            bufCnt_d = bufCnt_d - 2'h1;
        end
        if (push) begin
            buf_d[bufCnt_d[0]] = pushWord;
            bufCnt_d = bufCnt_d + 2'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (wrEn) begin
            mem[wrPtr_q] <= sampleData;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rec_q <= REC_IDLE;      rd_q <= RD_IDLE;
            stop_q <= SRR_STOP_RST; size_q <= SRR_SIZE_RST;
            trig_q <= SRR_TRIG_RST; gap_q <= SRR_GAP_RST;
            chan_q <= SRR_CHAN_RST; gapCnt_q <= 16'h0;
            done_q <= 1'b0;         withData_q <= 1'b0;
            filled_q <= 11'h0;      remain_q <= 11'h0;
            wrPtr_q <= 10'h0;       rdIdx_q <= 10'h0;
            cur_q <= 10'h0;         wrTot_q <= 17'h0;
            rdTot_q <= 17'h0;       hdrCnt_q <= 2'h0;
            errValid_q <= 1'b0;     err_q <= SRR_ERR_NONE;
            ready_q <= 1'b0;        bufCnt_q <= 2'h0;
            outValid_q <= 1'b0;     buf_q[0] <= '0;
            buf_q[1] <= '0;
            lock_q <= 1'b0;
        end else begin
            rec_q <= rec_d;         rd_q <= rd_d;
            stop_q <= stop_d;       size_q <= size_d;
            trig_q <= trig_d;       gap_q <= gap_d;
            chan_q <= chan_d;       gapCnt_q <= gapCnt_d;
            done_q <= done_d;       withData_q <= withData_d;
            filled_q <= filled_d;   remain_q <= remain_d;
            wrPtr_q <= wrPtr_d;     rdIdx_q <= rdIdx_d;
            cur_q <= cur_d;         wrTot_q <= wrTot_d;
            rdTot_q <= rdTot_d;     hdrCnt_q <= hdrCnt_d;
            errValid_q <= errValid_d; err_q <= err_d;
            ready_q <= ready_d;     bufCnt_q <= bufCnt_d;
            outValid_q <= (bufCnt_d != 2'h0);
            buf_q[0] <= buf_d[0];   buf_q[1] <= buf_d[1];
            lock_q <= lock_d;
        end
    end

    assign cmdReady          = ready_q;
    assign outValid          = outValid_q;
    assign outWord           = buf_q[0];
    assign recordingComplete = done_q;
    assign settingsLocked    = lock_q;
    assign errValid          = errValid_q;
    assign errCode           = err_q;
    assign sectionSize       = size_q;
    assign stopType          = stop_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_arm_clears_done: assert property (
        accept && cmd.code == SRR_CMD_ARM
        |=> !recordingComplete && settingsLocked)
        else $error("arm did not clear completion flag");
    a_arm_index_zero: assert property (
        accept && cmd.code == SRR_CMD_ARM
        |=> rdIdx_q == 10'h0 && filled_q == 11'h0)
        else $error("arm did not reset index and data");
    a_lock_refuses_set: assert property (
        accept && isSetting(cmd.code) && settingsLocked
        |=> errValid && errCode == SRR_ERR_LOCKED
        && $stable(sectionSize) && $stable(stopType))
        else $error("setting changed while locked");
    a_busy_section: assert property (
        accept && cmd.code == SRR_CMD_SECTION && settingsLocked && !stopType
        |=> errValid && errCode == SRR_ERR_BUSY ##1 !outValid)
        else $error("section read during single recording");
    a_overflow_error: assert property (
        accept && cmd.code == SRR_CMD_SECTION && stopType
        && unread > 17'(SRR_FULL)
        |=> errValid && errCode == SRR_ERR_OVERFLOW && rd_q == RD_IDLE)
        else $error("overrun not reported");
    // a new command can start data at the fifth cycle at the earliest
    a_header_no_data: assert property (
        accept && cmd.code == SRR_CMD_HEADER
        |=> (!withData_q && rd_q != RD_DATA) [*4])
        else $error("header request produced samples");
    a_once_finishes: assert property (
        wrEn && !stopType && wrPtr_q == SRR_LAST
        && !(accept && cmd.code == SRR_CMD_ARM)
        |=> recordingComplete && !settingsLocked)
        else $error("single fill did not finish");
    a_cont_wraps: assert property (
        wrEn && stopType && wrPtr_q == SRR_LAST && !accept
        |=> rec_q == REC_RUN && wrPtr_q == 10'h0 && !recordingComplete)
        else $error("continuous recording stopped at wrap");
    a_off_stops: assert property (
        accept && cmd.code == SRR_CMD_OFF |=> !wrEn && !settingsLocked)
        else $error("writing continued after off");

endmodule

// ### verification/sample_recorder_readout_test.sv
/*
 * Self-checking bench of srr_recorder driven by the host model.
 * Assumes srr_pkg and srr_host_model are compiled first.
 */
`timescale 1ns/1ns
module sample_recorder_readout_test;
    import srr_pkg::*;
    typedef struct {
        srr_cmd_e    code;
        logic [15:0] arg;
        logic [15:0] expSize;
        logic        expStop;
    } srr_row_s;
    logic        mclk        = 1'b0;
    logic        nrst        = 1'b0;
    logic        sampleValid = 1'b0;
    logic [15:0] sampleData  = 16'h0000;
    logic        trigPin     = 1'b0;
    logic        cmdValid, cmdReady, outValid, outReady, errValid;
    logic        recordingComplete, settingsLocked, stopType;
    srr_cmd_s    cmd;
    srr_word_s   outWord;
    srr_err_e    errCode;
    logic [15:0] sectionSize;
    int          failures    = 0;
    int          compares    = 0;
    srr_row_s    rows[8] = '{
        '{SRR_CMD_SET_SIZE, 16'hFFFF, 16'hFFFF, 1'b0},
        '{SRR_CMD_SET_SIZE, 16'h0000, 16'h0000, 1'b0},
        '{SRR_CMD_SET_STOP, 16'h0001, 16'h0000, 1'b1},
        '{SRR_CMD_SET_STOP, 16'h0000, 16'h0000, 1'b0},
        '{SRR_CMD_SET_SIZE, 16'h0003, 16'h0003, 1'b0},
        '{SRR_CMD_SET_TRIG, 16'h0000, 16'h0003, 1'b0},
        '{SRR_CMD_SET_GAP,  16'h0001, 16'h0003, 1'b0},
        '{SRR_CMD_SET_CHAN, 16'h0000, 16'h0003, 1'b0}};

    srr_recorder uut (
        .mclk(mclk), .nrst(nrst), .cmdValid(cmdValid), .cmd(cmd),
        .cmdReady(cmdReady), .sampleValid(sampleValid),
        .sampleData(sampleData), .trigPin(trigPin), .outValid(outValid),
        .outWord(outWord), .outReady(outReady),
        .recordingComplete(recordingComplete),
        .settingsLocked(settingsLocked), .errValid(errValid),
        .errCode(errCode), .sectionSize(sectionSize), .stopType(stopType));
    srr_host_model host (
        .mclk(mclk), .cmdValid(cmdValid), .cmd(cmd), .cmdReady(cmdReady),
        .outValid(outValid), .outWord(outWord), .outReady(outReady));

    initial forever #5 mclk = ~mclk;

    task automatic conclude();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic send(input srr_cmd_e code, input logic [15:0] arg);
        int n;
        n = 0;
        host.words.delete();
        host.issue(code, arg);
        repeat (3) @(negedge mclk);
        // stream fully drained before the caller looks at it
        while ((cmdReady !== 1'b1 || outValid !== 1'b0) && n < 3000) begin
            @(negedge mclk);
            n++;
        end
        chk(18'(host.n >= 200 || n >= 3000), 18'h0);
    endtask
    // one sample every other cycle; data scrambled between strobes
    task automatic feed(input int cnt, input logic [15:0] base);
        for (int i = 0; i < cnt; i++) begin
            @(negedge mclk);
            sampleValid = 1'b1;
            sampleData  = base + 16'(i);
            @(negedge mclk);
            sampleValid = 1'b0;
            sampleData  = ~sampleData;
        end
    endtask
    task automatic sec(input int cnt, input logic [15:0] base);
        send(SRR_CMD_SECTION, base);
        chk(18'(host.words.size()), 18'(cnt));
        foreach (host.words[i]) begin
            chk(host.words[i], {SRR_KIND_DATA, i == cnt - 1, base + 16'(i)});
        end
    endtask
    // header alone: last flag on its third word
    task automatic hdr(input logic [15:0] count);
        logic [15:0] e[3];
        e = '{count, SRR_GAP_RST, SRR_CHAN_RST};
        send(SRR_CMD_HEADER, 16'h0000);
        chk(18'(host.words.size()), 18'h3);
        foreach (host.words[i]) begin
            if (i < 3) begin
                chk(host.words[i], {SRR_KIND_HDR, i == 2, e[i]});
            end
        end
    endtask

    initial begin
        repeat (60000) @(posedge mclk);
        failures++;
        conclude();
    end

    initial begin
        repeat (16) @(negedge mclk);
        chk(sectionSize, SRR_SIZE_RST);
        chk(stopType, SRR_STOP_RST);
        nrst = 1'b1;
        foreach (rows[i]) begin
            send(rows[i].code, rows[i].arg);
            chk(sectionSize, rows[i].expSize);
            chk(stopType, rows[i].expStop);
        end
        send(SRR_CMD_NOP, 16'h0000);
        chk(errCode, SRR_ERR_BADCMD);
        hdr(16'h0000);
        send(SRR_CMD_SECTION, 16'h0000);
        chk(errCode, SRR_ERR_EMPTY);
        send(SRR_CMD_ARM, 16'h0000);
        chk(settingsLocked, 1'b1);
        send(SRR_CMD_SET_SIZE, 16'h0009);
        chk(errCode, SRR_ERR_LOCKED);
        chk(sectionSize, 16'h0003);
        send(SRR_CMD_SECTION, 16'h0000);
        chk(errCode, SRR_ERR_BUSY);
        feed(1024, 16'h0000);
        repeat (2) @(negedge mclk);
        chk(recordingComplete, 1'b1);
        chk(settingsLocked, 1'b0);
        feed(5, 16'h8000);
        hdr(16'h0400);
        host.slow = 1'b1;
        sec(3, 16'h0000);
        host.slow = 1'b0;
        sec(3, 16'h0003);
        host.idx = 1'b1;
        sec(3, 16'h0064);
        host.idx = 1'b0;
        send(SRR_CMD_ARM, 16'h0000);
        chk(recordingComplete, 1'b0);
        hdr(16'h0000);
        feed(1024, 16'h1000);
        repeat (2) @(negedge mclk);
        sec(3, 16'h1000);
        for (int t = 1; t < 3; t++) begin
            trigPin = (t == 2);
            send(SRR_CMD_SET_TRIG, 16'(t));
            send(SRR_CMD_ARM, 16'h0000);
            feed(4, 16'h0000);
            send(SRR_CMD_OFF, 16'h0000);
            hdr(16'h0000);
            send(SRR_CMD_ARM, 16'h0000);
            trigPin = (t == 1);
            repeat (8) @(negedge mclk);
            feed(4, 16'h0000);
            send(SRR_CMD_OFF, 16'h0000);
            chk(settingsLocked, 1'b0);
            feed(4, 16'h0000);
            hdr(16'h0004);
        end
        send(SRR_CMD_SET_TRIG, 16'h0000);
        send(SRR_CMD_SET_SIZE, 16'h03E8);
        send(SRR_CMD_SET_STOP, 16'h0001);
        send(SRR_CMD_ARM, 16'h0000);
        feed(1020, 16'h0000);
        sec(1000, 16'h0000);
        feed(20, 16'h03FC);
        sec(40, 16'h03E8);
        feed(1100, 16'h2000);
        send(SRR_CMD_SECTION, 16'h0000);
        chk(errCode, SRR_ERR_OVERFLOW);
        send(SRR_CMD_OFF, 16'h0000);
        chk(settingsLocked, 1'b0);
        send(SRR_CMD_FULL, 16'h0000);
        chk(18'(host.words.size()), 18'h403);
        chk(host.words[0], {SRR_KIND_HDR, 1'b0, 16'h0400});
        chk(host.words[3], {SRR_KIND_DATA, 1'b0, 16'h204C});
        chk(host.words[1026], {SRR_KIND_DATA, 1'b1, 16'h244B});
        nrst = 1'b0;
        @(negedge mclk);
        chk(stopType, SRR_STOP_RST);
        nrst = 1'b1;
        hdr(16'h0000);
        conclude();
    end
endmodule

// ### verification/srr_host_model.sv
/*
 * Host model: issues recorder commands, collects readout words.
 * Assumes the command port and stream of srr_recorder on mclk.
 */
`timescale 1ns/1ns
module srr_host_model
    import srr_pkg::*;
(
    // clock
    input  wire logic      mclk,
    // command side
    output logic           cmdValid,
    output srr_cmd_s       cmd,
    input  wire logic      cmdReady,
    // stream side
    input  wire logic      outValid,
    input  wire srr_word_s outWord,
    output logic           outReady
);
    srr_word_s words[$];
    logic      slow = 1'b0;
    logic      idx  = 1'b0;
    int        n;

    initial begin
        cmdValid = 1'b0;
        cmd      = '0;
        outReady = 1'b0;
    end
    // slow sink stalls every other cycle
    // words logged half a cycle clear of the edge that launches them
    always @(negedge mclk) begin
        if (outValid && (!slow || !outReady)) begin
            words.push_back(outWord);
        end
        outReady <= slow ? ~outReady : 1'b1;
    end
    // held until taken; payload scrambled after, no stale value
    task automatic issue(input srr_cmd_e code, input logic [15:0] arg);
        @(negedge mclk);
        cmdValid = 1'b1;
        cmd      = '{code, idx, arg};
        n        = 0;
        while (cmdReady !== 1'b1 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        @(negedge mclk);
        cmdValid = 1'b0;
        cmd      = ~cmd;
    endtask
endmodule
